// ==== include/sdl_pkg.sv ====
package sdl_pkg;
    // Word framing
    localparam int WORD_W = 16;
    localparam int BIT_CNT_W = 4;
    localparam logic [BIT_CNT_W-1:0] LAST_BIT = 4'hF;
    // Resolutions and code formats
    localparam int RES_16 = 16;
    localparam int RES_14 = 14;
    localparam int RES_12 = 12;
    localparam logic [WORD_W-1:0] ZERO_CODE = 16'h0000;
    localparam logic [WORD_W-1:0] MID_CODE = 16'h8000;
    // Segmented ladder split
    localparam int SEG_BITS = 4;
    localparam int SEG_CNT = 15;
    localparam int LOW_W = WORD_W - SEG_BITS;
    // Buffer shape
    localparam int FIFO_DEPTH = 4;
    // Timing
    localparam int MCLK_NS = 100;
    localparam int CLR_MIN_NS = 15;
    localparam int CSH_MIN_NS = 10;
    localparam int CLR_CYCLES = (CLR_MIN_NS + MCLK_NS - 1) / MCLK_NS;
    localparam int CSH_CYCLES = (CSH_MIN_NS + MCLK_NS - 1) / MCLK_NS;
    localparam int TCNT_W = 4;

    // Host sequencer states, Gray coded along the frame
    typedef enum logic [2:0] {
        SDL_IDLE = 3'h0,
        SDL_SCLO = 3'h1,
        SDL_SCHI = 3'h3,
        SDL_DONE = 3'h2,
        SDL_GAP = 3'h6
    } sdl_state_e;

    // Power-on and clear code of a variant, left-justified in the word
    function automatic logic [WORD_W-1:0] sdlResetCode(input bit bipolar);
        sdlResetCode = bipolar ? MID_CODE : ZERO_CODE;
    endfunction

    // Thermometer decode of the top bits into equal segment controls
    function automatic logic [SEG_CNT-1:0] sdlThermo(input logic [SEG_BITS-1:0] top);
        logic [SEG_CNT-1:0] t;
        t = '0;
        for (int i = 0; i < SEG_CNT; i++)
        begin
            t[i] = (top > i[SEG_BITS-1:0]);
        end
        sdlThermo = t;
    endfunction
endpackage

// ==== include/sdl_link_if.sv ====
`timescale 1ns/1ps
interface sdl_link_if;
    logic csN;   // Word frame select, active low
    logic sclk;  // Shift clock made by the host
    logic din;   // Serial data, MSB first
    logic clearN; // Asynchronous clear, active low

    modport host (output csN, output sclk, output din, output clearN);
    modport dac (input csN, input sclk, input din, input clearN);
endinterface

// ==== design/sdl_dac_end.sv ====
`timescale 1ns/1ps
// Overview of operation
// - Shift data on rising clock, MSB first
// - Select rise copies 16 bits into latch
// - Select high disables shift register
// - Short frame invalid; host resends whole word
// - Long frame keeps only last 16 bits
// - 14-bit code left-justified, two pad bits
// - 12-bit code left-justified, four pad bits
// - Unipolar power-up latch to zero
// - Bipolar power-up latch to midscale
// - Clear low forces reset code asynchronously
// - Unipolar code is straight binary
// - Bipolar code is offset binary
// - Top four bits drive fifteen segments
module sdl_dac_end
    import sdl_pkg::*;
#(
    parameter int RES = RES_16,   // Resolution: 16, 14 or 12
    parameter bit BIPOLAR = 1'b0  // 0: zero-scale variant, 1: midscale variant
)
(
    sdl_link_if.dac link,                   // Serial link from the host
    input wire logic rst,                   // Power-on reset, active high
    output logic [WORD_W-1:0] latchCode,    // Converter latch, left-justified
    output logic [RES-1:0] unipolarCode,    // Straight binary code k
    output logic signed [RES-1:0] bipolarCode, // Offset binary as signed value
    output logic [SEG_CNT-1:0] segments,    // Equal weighted segment controls
    output logic [LOW_W-1:0] lowerBits      // Binary weighted lower sections
);
    localparam logic [WORD_W-1:0] RESET_CODE = sdlResetCode(BIPOLAR);

    logic [WORD_W-1:0] shift_q;
    logic [WORD_W-1:0] latch_q;
    wire clearAll;

    // Shifting runs only while the frame is open; extra edges push old bits out
    always_ff @(posedge link.sclk)
    begin
        if (!link.csN)
        begin
            shift_q <= {shift_q[WORD_W-2:0], link.din};
        end
    end

    // Power-on folds into clear; both only ever load a constant
    assign clearAll = rst | ~link.clearN;

    // Select rise ends the frame; the link clock may already have stopped
    always_ff @(posedge link.csN or posedge clearAll)
    begin
        if (clearAll)
        begin
            latch_q <= RESET_CODE;
        end
        else
        begin
            latch_q <= shift_q;
        end
    end

    // Code views; short resolutions drop their padding bits
    assign latchCode = latch_q;
    assign unipolarCode = latch_q[WORD_W-1 -: RES];
    assign bipolarCode = $signed({~latch_q[WORD_W-1], latch_q[WORD_W-2 -: RES-1]});
    assign segments = sdlThermo(latch_q[WORD_W-1 -: SEG_BITS]);
    assign lowerBits = latch_q[LOW_W-1:0];
endmodule

// ==== design/sdl_host_end.sv ====
`timescale 1ns/1ps
// Word buffer between the user and the serial sequencer
module sdl_fifo
#(
    parameter int WIDTH = 16,  // Word width
    parameter int DEPTH = 4    // Number of words
)
(
    input wire logic mclk,             // System clock
    input wire logic rst,              // Synchronous reset, active high
    input wire logic inValid,          // Write request
    output logic inReady,              // Room for a word
    input wire logic [WIDTH-1:0] inData, // Write data
    output logic outValid,             // Word available
    input wire logic outReady,         // Read accept
    output logic [WIDTH-1:0] outData   // Head word
);
    localparam int PW = $clog2(DEPTH);
    localparam logic [PW:0] FULL_CNT = DEPTH[PW:0];

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW-1:0] wrPtr_q;
    logic [PW-1:0] rdPtr_q;
    logic [PW:0] count_q;
    wire doWr;
    wire doRd;

    // Honest flags from the word count
    assign inReady = (count_q != FULL_CNT);
    assign outValid = (count_q != '0);
    assign doWr = inValid & inReady;
    assign doRd = outValid & outReady;
    assign outData = mem_q[rdPtr_q];

    always_ff @(posedge mclk)
    begin
        if (doWr)
        begin
            mem_q[wrPtr_q] <= inData;
        end
    end

    // Pointers wrap at the power-of-two depth
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            count_q <= '0;
        end
        else
        begin
            wrPtr_q <= wrPtr_q + PW'(doWr);
            rdPtr_q <= rdPtr_q + PW'(doRd);
            count_q <= count_q + (PW+1)'(doWr) - (PW+1)'(doRd);
        end
    end
endmodule

// Host controller: drains words into serial frames, makes the shift clock
module sdl_host_end
    import sdl_pkg::*;
(
    input wire logic mclk,                // System clock, 10 MHz
    input wire logic rst,                 // Synchronous reset, active high
    input wire logic wordValid,           // User word offered
    output logic wordReady,               // Buffer accepts the word
    input wire logic [WORD_W-1:0] wordData, // Left-justified code
    input wire logic clearReq,            // Pulse or level asking for a clear
    output logic busy,                    // Frame in progress
    sdl_link_if.host link                 // Serial link to the converter
);
    sdl_state_e state_q;
    sdl_state_e state_d;
    logic [WORD_W-1:0] shift_q;
    logic [BIT_CNT_W-1:0] bitCnt_q;
    logic csN_q;
    logic sclk_q;
    logic din_q;
    logic [TCNT_W-1:0] clrCnt_q;
    logic clearN_q;
    logic [TCNT_W-1:0] gapCnt_q;
    wire headValid;
    wire [WORD_W-1:0] headData;
    wire takeWord;
    wire lastBit;

    sdl_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .mclk(mclk),
        .rst(rst),
        .inValid(wordValid),
        .inReady(wordReady),
        .inData(wordData),
        .outValid(headValid),
        .outReady(takeWord),
        .outData(headData)
    );

    // Popping only in idle stalls the buffer while a frame runs
    assign takeWord = (state_q == SDL_IDLE) & headValid;
    assign lastBit = (bitCnt_q == LAST_BIT);
    assign busy = (state_q != SDL_IDLE);

    // Each bit spends one cycle low then one high, so the clock is mclk/2
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            SDL_IDLE: state_d = takeWord ? SDL_SCLO : SDL_IDLE;
            SDL_SCLO: state_d = SDL_SCHI;
            SDL_SCHI: state_d = lastBit ? SDL_DONE : SDL_SCLO;
            SDL_DONE: state_d = SDL_GAP;
            SDL_GAP: state_d = (gapCnt_q == '0) ? SDL_IDLE : SDL_GAP;
            default: state_d = SDL_IDLE;
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            state_q <= SDL_IDLE;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // Pin drivers; data changes on falling clock for full setup margin
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            csN_q <= 1'b1;
            sclk_q <= 1'b0;
            din_q <= 1'b0;
            shift_q <= '0;
            bitCnt_q <= '0;
            gapCnt_q <= '0;
        end
        else
        begin
            case (state_q)
                SDL_IDLE:
                begin
                    if (takeWord)
                    begin
                        csN_q <= 1'b0;
                        din_q <= headData[WORD_W-1];
                        shift_q <= {headData[WORD_W-2:0], 1'b0};
                        bitCnt_q <= '0;
                    end
                end
                SDL_SCLO: sclk_q <= 1'b1;
                SDL_SCHI:
                begin
                    sclk_q <= 1'b0;
                    if (!lastBit)
                    begin
                        din_q <= shift_q[WORD_W-1];
                        shift_q <= {shift_q[WORD_W-2:0], 1'b0};
                        bitCnt_q <= bitCnt_q + 4'h1;
                    end
                end
                SDL_DONE:
                begin
                    csN_q <= 1'b1;
                    gapCnt_q <= TCNT_W'(CSH_CYCLES - 1);
                end
                SDL_GAP: gapCnt_q <= (gapCnt_q == '0) ? gapCnt_q : gapCnt_q - 4'h1;
                default: csN_q <= 1'b1;
            endcase
        end
    end

    // Clear pulse is stretched to its least width; a held request keeps it low
    // The pin comes from a flop, so a counter step cannot glitch the async clear
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            clrCnt_q <= '0;
            clearN_q <= 1'b1;
        end
        else if (clearReq)
        begin
            clrCnt_q <= TCNT_W'(CLR_CYCLES);
            clearN_q <= 1'b0;
        end
        else if (clrCnt_q != '0)
        begin
            clrCnt_q <= clrCnt_q - 4'h1;
            clearN_q <= (clrCnt_q == 4'h1);
        end
    end

    assign link.csN = csN_q;
    assign link.sclk = sclk_q;
    assign link.din = din_q;
    assign link.clearN = clearN_q;
endmodule

// ==== sim/sdl_link_checker.sv ====
`timescale 1ns/1ps
// Watches the serial link between the two ends and the converter latch
module sdl_link_checker
(
    input wire logic mclk,             // System clock
    input wire logic rst,              // Synchronous reset, active high
    input wire logic csN,              // Frame select
    input wire logic sclk,             // Shift clock
    input wire logic din,              // Serial data
    input wire logic clearN,           // Clear, active low
    input wire logic [15:0] latchCode  // Converter latch
);
    logic [15:0] shadow_q;
    logic [4:0] edge_q;

    // Follows the wire in mclk; safe because the host moves sclk only on mclk
    always_ff @(posedge mclk)
    begin
        if ($rose(sclk) && !csN)
            shadow_q <= {shadow_q[14:0], din};
        if (csN)
            edge_q <= 5'h00;
        else if ($rose(sclk))
            edge_q <= edge_q + 5'h01;
    end

    default clocking @(posedge mclk); endclocking
    default disable iff (rst);

    sequence firstRise;
        !sclk ##1 sclk;
    endsequence

    idle_clock_a: assert property (csN |-> !sclk)
        else $error("shift clock moved outside a frame");
    first_rise_a: assert property ($fell(csN) |-> firstRise)
        else $error("first shift edge not one cycle after select");
    clock_shape_a: assert property ($rose(sclk) |=> !sclk)
        else $error("shift clock high too long");
    din_hold_a: assert property ($rose(sclk) |-> $stable(din))
        else $error("data moved at shift edge");
    word_count_a: assert property ($rose(csN) |-> edge_q == 5'h10)
        else $error("frame without sixteen shift edges");
    latch_load_a: assert property ($rose(csN) && clearN |-> latchCode == shadow_q)
        else $error("latch differs from shifted word");
    clear_code_a: assert property (!clearN |-> latchCode == 16'h0000)
        else $error("clear did not force zero code");
    // Back-to-back frames leave select high for two mclk samples
    cs_gap_a: assert property ($rose(csN) |-> csN [*2])
        else $error("select high gap too short");
endmodule

// ==== sim/tb_top.sv ====
`timescale 1ns/1ps
// Host end into a zero-scale 16-bit end; bench drives a midscale 12-bit
// and a zero-scale 14-bit end on one shared link
module tb_top;
    import sdl_pkg::*;
    logic mclk = 1'b0;
    logic rst = 1'b0;  // Raised after time zero so the async latch reset sees an edge
    logic wordValid = 1'b0;
    logic [WORD_W-1:0] wordData = 16'h0000;
    logic clearReq = 1'b0;
    logic wordReady, busy;
    logic [WORD_W-1:0] codeA, codeB, codeC;
    logic [15:0] uniA;
    logic signed [15:0] bipA;
    logic [11:0] uniB;
    logic signed [11:0] bipB;
    logic [13:0] uniC;
    logic [SEG_CNT-1:0] segA;
    logic [LOW_W-1:0] lowA;
    int n_fail = 0;
    int n_tests = 0;
    int cycles = 0;
    // Word, segment controls, offset-binary view of the 16-bit latch
    logic [15:0] rows [5][3] = '{
        '{16'h0000, 16'h0000, 16'h8000},
        '{16'hFFFF, 16'h7FFF, 16'h7FFF},
        '{16'h8000, 16'h00FF, 16'h0000},
        '{16'h0001, 16'h0000, 16'h8001},
        '{16'hA5C3, 16'h03FF, 16'h25C3}
    };

    sdl_link_if linkA ();
    sdl_link_if linkB ();
    always #50 mclk = ~mclk;

    sdl_host_end u_sdl_host_end (.mclk(mclk), .rst(rst), .wordValid(wordValid),
        .wordReady(wordReady), .wordData(wordData), .clearReq(clearReq), .busy(busy),
        .link(linkA));
    sdl_dac_end #(.RES(RES_16), .BIPOLAR(1'b0)) u_sdl_dac_end (.link(linkA), .rst(rst),
        .latchCode(codeA), .unipolarCode(uniA), .bipolarCode(bipA), .segments(segA),
        .lowerBits(lowA));
    sdl_dac_end #(.RES(RES_12), .BIPOLAR(1'b1)) u_sdl_dac_end_b (.link(linkB), .rst(rst),
        .latchCode(codeB), .unipolarCode(uniB), .bipolarCode(bipB), .segments(),
        .lowerBits());
    // Second listener on the bench's link; every frame lands in both latches
    sdl_dac_end #(.RES(RES_14), .BIPOLAR(1'b0)) u_sdl_dac_end_c (.link(linkB), .rst(rst),
        .latchCode(codeC), .unipolarCode(uniC), .bipolarCode(), .segments(),
        .lowerBits());
    sdl_link_checker u_sdl_link_checker (.mclk(mclk), .rst(rst), .csN(linkA.csN),
        .sclk(linkA.sclk), .din(linkA.din), .clearN(linkA.clearN), .latchCode(codeA));

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("unexpected at %0t: saw %h, want %h", $time, seen, exp);
        end
    endtask

    task automatic close_out();
        $display("comparisons %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Cuts a hang short; all tests need well under a thousand cycles
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            n_fail++;
            close_out();
        end
    end

    // busy dips between frames, so quiet must last several cycles
    task automatic settle();
        int q = 0;
        while (q < 4)
        begin
            @(posedge mclk);
            q = (busy === 1'b1) ? 0 : q + 1;
        end
        #10;
    endtask

    task automatic push(input logic [15:0] w);
        wordValid = 1'b1;
        wordData = w;
        @(posedge mclk);
        #10 wordValid = 1'b0;
        settle();
    endtask

    // Bench as host on the second link; the task moves sclk only while its frame is open
    task automatic sendB(input logic [31:0] w, input int n, input logic clr);
        linkB.csN = 1'b0;
        for (int i = n - 1; i >= 0; i--)
        begin
            linkB.din = w[i];
            #80 linkB.sclk = 1'b1;
            #80 linkB.sclk = 1'b0;
        end
        linkB.clearN = ~clr;
        #80 linkB.csN = 1'b1;
        linkB.din = ~linkB.din;
        #80 linkB.clearN = 1'b1;
    endtask

    initial
    begin
        logic [15:0] last;
        int full;
        linkB.csN = 1'b1;
        linkB.sclk = 1'b0;
        linkB.din = 1'b0;
        linkB.clearN = 1'b1;
        #1 rst = 1'b1;
        repeat (8) @(posedge mclk);
        #10 rst = 1'b0;
        chk(codeA, 16'h0000);
        chk(codeB, 16'h8000);
        chk(codeC, 16'h0000);
        chk({4'h0, bipB}, 16'h0000);
        $display("reset test done");
        foreach (rows[i])
        begin
            push(rows[i][0]);
            chk(codeA, rows[i][0]);
            chk(uniA, rows[i][0]);
            chk(bipA, rows[i][2]);
            chk({1'b0, segA}, rows[i][1]);
            chk({4'h0, lowA}, {4'h0, rows[i][0][11:0]});
        end
        $display("word table done");
        // Offer six words back to back; the buffer must refuse some
        full = 0;
        for (int i = 0; i < 6; i++)
        begin
            wordValid = 1'b1;
            wordData = 16'(16'h1111 * (i + 1));
            if (wordReady === 1'b1)
                last = wordData;
            else
                full++;
            @(posedge mclk);
            #10;
        end
        wordValid = 1'b0;
        settle();
        chk(codeA, last);
        chk(16'(full > 0), 16'h0001);
        clearReq = 1'b1;
        @(posedge mclk);
        #10 clearReq = 1'b0;
        settle();
        chk(codeA, 16'h0000);
        $display("buffer and clear test done");
        sendB(32'h000ABCDE, 20, 1'b0);
        chk(codeB, 16'hBCDE);
        chk({4'h0, uniB}, 16'h0BCD);
        chk({4'h0, bipB}, 16'h03CD);
        chk(codeC, 16'hBCDE);
        chk({2'b00, uniC}, 16'h2F37);
        sendB(32'h00005678, 16, 1'b0);
        linkB.din = 1'b1;
        repeat (4)
        begin
            #80 linkB.sclk = 1'b1;
            #80 linkB.sclk = 1'b0;
        end
        sendB(32'h000009AB, 12, 1'b0);
        chk(codeB, 16'h89AB);
        chk(codeC, 16'h89AB);
        sendB(32'h0000FFFF, 16, 1'b1);
        chk(codeB, 16'h8000);
        chk(codeC, 16'h0000);
        $display("second link test done");
        // Reset in mid-run: every latch falls back to its power-on code
        @(posedge mclk);
        #10;
        push(16'h4321);
        chk(codeA, 16'h4321);
        sendB(32'h00001234, 16, 1'b0);
        chk(codeB, 16'h1234);
        @(posedge mclk);
        #10 rst = 1'b1;
        repeat (2) @(posedge mclk);
        #10 rst = 1'b0;
        chk(codeA, 16'h0000);
        chk(codeB, 16'h8000);
        chk(codeC, 16'h0000);
        chk({4'h0, bipB}, 16'h0000);
        $display("mid-run reset test done");
        close_out();
    end
endmodule
